/* File: design/slic_pkg.sv */
// slic_pkg: shared constants and types for the automatic activation control
// assumes core_clk at 250 MHz; all pin inputs are asynchronous
package slic_pkg;
  localparam int CLK_PERIOD_PS = 4000;
  // shortest low phase of the ring clock, in ns
  localparam int RING_LOW_MIN_NS = 1;
  localparam int RING_LOW_MIN_CYC =
    ((RING_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS) < 1 ? 1 :
    ((RING_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  // on-hook persistence before fallback, in ring clock periods
  localparam int ONHOOK_RING_PERIODS = 128;
  // stand-by validation time, in ring clock periods
  localparam int STANDBY_RING_PERIODS = 2;
  localparam int SYNC_STAGES = 2;

  // mode word values, mode_bit_0 is the leading bit
  localparam logic [2:0] MODE_POWER_DOWN = 3'h0;
  localparam logic [2:0] MODE_RINGING = 3'h1;
  localparam logic [2:0] MODE_OHT_REVERSE = 3'h2;
  localparam logic [2:0] MODE_OHT_DIRECT = 3'h3;
  localparam logic [2:0] MODE_ACT_REVERSE = 3'h6;
  localparam logic [2:0] MODE_RESET_VALUE = 3'h4;
  localparam logic [1:0] RELAY_RESET_VALUE = 2'h0;

  typedef enum logic [2:0] {
    SLIC_OP_POWER_DOWN,
    SLIC_OP_RINGING,
    SLIC_OP_OHT_REVERSE,
    SLIC_OP_OHT_DIRECT,
    SLIC_OP_ACT_REVERSE,
    SLIC_OP_ACT_DIRECT
  } slic_op_e;

  typedef enum logic [1:0] {
    SLIC_ST_HI_FEED,
    SLIC_ST_STANDBY,
    SLIC_ST_ACTIVE
  } slic_auto_e;

  // latched word from the control bus
  typedef struct packed {
    logic [2:0] mode;
    logic [1:0] relay;
  } slic_latch_s;

  // line condition inputs after synchronisation
  typedef struct packed {
    logic off_hook;
    logic ground_key;
    logic ring_trip;
    logic power_cross;
    logic long_fault;
    logic thermal;
  } slic_line_s;

  // status pin group: value and enable of each tri-state output
  typedef struct packed {
    logic hook_o;
    logic hook_oe;
    logic gka_o;
    logic gka_oe;
  } slic_status_s;
endpackage

/* File: design/slic_sync.sv */
// slic_sync: two-stage synchroniser for a bundle of asynchronous levels
// assumes inputs are quasi-static levels; no pulse shorter than a clock
`timescale 1ns/1ps
module slic_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  // first stage feeds only the second stage
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule

/* File: design/slic_ctrl.sv */
// slic_ctrl: control logic of a line interface in automatic activation mode
// assumes all pins are asynchronous to core_clk, which stands in for the
// free-running internal oscillator; analog detectors arrive as levels
`timescale 1ns/1ps
// What this block does
// - bus has separate select for writing latch and for reading status
// - under active mode device picks active, stand-by or hi-feed itself
// - power-down disables all but the two test relay drivers
// - power-down, reset and thermal alarm differ in relays and outputs
// - ringing energises relay; ring trip drops hook output, releases relay
// - hook output stays low after ring trip until mode word changes, device reset or thermal alarm
// - ringing relay switches on only while ring clock is low
// - on-hook transmission stays set for conversation while on-hook
// - any mode word with leading one is active mode
// - hi-feed entered after reset or active word, held while on-hook
// - hi-feed always uses direct polarity
// - off-hook in hi-feed goes stand-by; confirmed goes active else back
// - in active state hook output follows line hook status live
// - active direct word falls back only after on-hook over 128 ring clock periods; active reverse never falls back
// - state machine runs from free-running internal clock
// - power-cross sense drives both outputs low outside ringing, mode unchanged
// - longitudinal fault holds both outputs low while it lasts, except in ringing
// - thermal overload forces power-down, outputs low, ring relay off
// - status output meaning depends on mode bits, thermal alarm and device reset
// - input select low captures mode and relay bits into latch
// - status outputs high impedance while output select high
// - each test relay bit drives its relay, one on, zero off
// - reset input low: power-down, relays off, outputs disabled
module slic_ctrl #(
  parameter int ONHOOK_PERIODS = slic_pkg::ONHOOK_RING_PERIODS,
  parameter int STANDBY_PERIODS = slic_pkg::STANDBY_RING_PERIODS
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // control bus
  input wire logic input_latch_select_n,
  input wire logic status_output_select_n,
  input wire logic mode_bit_0,
  input wire logic mode_bit_1,
  input wire logic mode_bit_2,
  input wire logic test_relay_bit_0,
  input wire logic test_relay_bit_1,
  input wire logic device_reset_n,
  // ring timing
  input wire logic ring_sync_clock,
  // line detectors
  input wire logic line_off_hook,
  input wire logic line_ground_key,
  input wire logic line_ring_trip,
  input wire logic power_cross_sense_in,
  input wire logic long_current_fault,
  input wire logic thermal_overload,
  // status pins
  output logic hook_detect_out,
  output logic hook_detect_oe,
  output logic ground_key_alarm_out,
  output logic ground_key_alarm_oe,
  // relay drivers
  output logic ringing_relay_drive,
  output logic test_relay_0,
  output logic test_relay_1,
  // analog mode controls
  output slic_pkg::slic_op_e op_mode,
  output slic_pkg::slic_auto_e auto_state,
  output logic reverse_polarity,
  output logic power_down_active
);
  localparam int NSYNC = 14;
  localparam int ONHOOK_W = $clog2(ONHOOK_PERIODS + 2);

  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] syn;
  slic_pkg::slic_line_s line;
  slic_pkg::slic_latch_s bus_word;
  slic_pkg::slic_latch_s latch_reg;
  slic_pkg::slic_status_s stat_next;
  slic_pkg::slic_status_s stat_reg;
  slic_pkg::slic_auto_e auto_reg;
  slic_pkg::slic_auto_e auto_next;
  logic sel_in_n;
  logic sel_out_n;
  logic dev_rst_n;
  logic ring_clk;
  logic ring_clk_reg;
  logic ring_period;
  logic latch_strobe;
  logic mode_changed;
  logic trip_reg;
  logic trip_next;
  logic relay_on_reg;
  logic relay_on_next;
  logic [ONHOOK_W-1:0] onhook_cnt_reg;
  logic [ONHOOK_W-1:0] onhook_cnt_next;
  logic [ONHOOK_W-1:0] sb_cnt_reg;
  logic [ONHOOK_W-1:0] sb_cnt_next;
  logic is_active_word;
  logic is_idle;
  logic fault_low;
  slic_pkg::slic_op_e op_dec;

  // mode word decode, applied only to the latched word
  function automatic slic_pkg::slic_op_e decode_mode(input logic [2:0] m);
    if (m == slic_pkg::MODE_POWER_DOWN) begin
      decode_mode = slic_pkg::SLIC_OP_POWER_DOWN;
    end else if (m == slic_pkg::MODE_RINGING) begin
      decode_mode = slic_pkg::SLIC_OP_RINGING;
    end else if (m == slic_pkg::MODE_OHT_REVERSE) begin
      decode_mode = slic_pkg::SLIC_OP_OHT_REVERSE;
    end else if (m == slic_pkg::MODE_OHT_DIRECT) begin
      decode_mode = slic_pkg::SLIC_OP_OHT_DIRECT;
    end else if (m == slic_pkg::MODE_ACT_REVERSE) begin
      decode_mode = slic_pkg::SLIC_OP_ACT_REVERSE;
    end else begin
      decode_mode = slic_pkg::SLIC_OP_ACT_DIRECT;
    end
  endfunction

  // every pin is asynchronous, so all pass two flops; active-low pins go in
  // inverted so a cleared flop reads idle and no zero word is latched
  assign raw_in = {~input_latch_select_n, ~status_output_select_n,
                   mode_bit_0, mode_bit_1, mode_bit_2, test_relay_bit_0,
                   test_relay_bit_1, ~device_reset_n, ring_sync_clock,
                   line_off_hook, line_ground_key, line_ring_trip,
                   power_cross_sense_in,
                   long_current_fault | thermal_overload};

  slic_sync #(
    .WIDTH(NSYNC)
  ) u_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in(raw_in),
    .sync_out(syn)
  );

  // thermal is kept apart from the fault bit through its own flag below
  logic thermal_s;
  logic thermal_meta;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      thermal_meta <= 1'b0;
      thermal_s <= 1'b0;
    end else begin
      thermal_meta <= thermal_overload;
      thermal_s <= thermal_meta;
    end
  end

  assign sel_in_n = ~syn[13];
  assign sel_out_n = ~syn[12];
  assign bus_word = '{mode: syn[11:9], relay: syn[8:7]};
  assign dev_rst_n = ~syn[6];
  assign ring_clk = syn[5];
  assign line = '{off_hook: syn[4], ground_key: syn[3], ring_trip: syn[2],
                  power_cross: syn[1], long_fault: syn[0] & ~thermal_s,
                  thermal: thermal_s};

  // latch is transparent while the input select is low
  assign latch_strobe = ~sel_in_n;
  assign mode_changed = latch_strobe && (bus_word.mode != latch_reg.mode);
  // rising edge of ring clock marks one period
  assign ring_period = ring_clk && !ring_clk_reg;

  assign op_dec = decode_mode(latch_reg.mode);
  assign is_active_word = latch_reg.mode[2];
  assign is_idle = !dev_rst_n || thermal_s ||
                   (op_dec == slic_pkg::SLIC_OP_POWER_DOWN);

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      latch_reg <= '{mode: slic_pkg::MODE_RESET_VALUE,
                     relay: slic_pkg::RELAY_RESET_VALUE};
      ring_clk_reg <= 1'b0;
    end else begin
      if (latch_strobe) begin
        latch_reg <= bus_word;
      end
      ring_clk_reg <= ring_clk;
    end
  end

  // automatic activation state machine, clocked by the internal clock
  always_comb begin
    auto_next = auto_reg;
    onhook_cnt_next = onhook_cnt_reg;
    sb_cnt_next = sb_cnt_reg;
    // a fresh active word or device reset restarts in hi-feed
    if (!is_active_word || !dev_rst_n || thermal_s ||
        (mode_changed && bus_word.mode[2])) begin
      auto_next = slic_pkg::SLIC_ST_HI_FEED;
      onhook_cnt_next = '0;
      sb_cnt_next = '0;
    end else begin
      case (auto_reg)
        slic_pkg::SLIC_ST_HI_FEED: begin
          sb_cnt_next = '0;
          onhook_cnt_next = '0;
          if (line.off_hook) begin
            auto_next = slic_pkg::SLIC_ST_STANDBY;
          end
        end
        slic_pkg::SLIC_ST_STANDBY: begin
          // validity check lasts a few ring periods of steady off-hook
          if (!line.off_hook) begin
            auto_next = slic_pkg::SLIC_ST_HI_FEED;
          end else if (ring_period) begin
            if (32'(sb_cnt_reg) + 1 >= STANDBY_PERIODS) begin
              auto_next = slic_pkg::SLIC_ST_ACTIVE;
              sb_cnt_next = '0;
            end else begin
              sb_cnt_next = sb_cnt_reg + 1'b1;
            end
          end
        end
        slic_pkg::SLIC_ST_ACTIVE: begin
          // dial pulses are shorter than the window and are ignored
          if (line.off_hook) begin
            onhook_cnt_next = '0;
          end else if (ring_period) begin
            if (32'(onhook_cnt_reg) >= ONHOOK_PERIODS) begin
              // only the direct word falls back; reverse stays active
              if (op_dec == slic_pkg::SLIC_OP_ACT_DIRECT) begin
                auto_next = slic_pkg::SLIC_ST_HI_FEED;
              end
            end else begin
              onhook_cnt_next = onhook_cnt_reg + 1'b1;
            end
          end
        end
        default: begin
          auto_next = slic_pkg::SLIC_ST_HI_FEED;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      auto_reg <= slic_pkg::SLIC_ST_HI_FEED;
      onhook_cnt_reg <= '0;
      sb_cnt_reg <= '0;
    end else begin
      auto_reg <= auto_next;
      onhook_cnt_reg <= onhook_cnt_next;
      sb_cnt_reg <= sb_cnt_next;
    end
  end

  // ring trip latch and ringing relay, cleared by a new mode word, device reset or thermal alarm
  always_comb begin
    trip_next = trip_reg;
    relay_on_next = relay_on_reg;
    if (op_dec != slic_pkg::SLIC_OP_RINGING || is_idle || mode_changed) begin
      trip_next = 1'b0;
      relay_on_next = 1'b0;
    end else if (line.ring_trip || trip_reg) begin
      trip_next = 1'b1;
      relay_on_next = 1'b0;
    end else if (!ring_clk) begin
      relay_on_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      trip_reg <= 1'b0;
      relay_on_reg <= 1'b0;
    end else begin
      trip_reg <= trip_next;
      relay_on_reg <= relay_on_next;
    end
  end

  // status outputs, which look at mode bits, detectors, device reset and output select
  assign fault_low = line.power_cross || line.long_fault;
  always_comb begin
    stat_next = '{hook_o: 1'b0, hook_oe: 1'b0, gka_o: 1'b0, gka_oe: 1'b0};
    if (!dev_rst_n) begin
      stat_next.hook_oe = 1'b0;
    end else if (thermal_s) begin
      stat_next = '{hook_o: 1'b0, hook_oe: 1'b1,
                    gka_o: 1'b0, gka_oe: 1'b1};
    end else if (op_dec == slic_pkg::SLIC_OP_POWER_DOWN) begin
      stat_next.hook_oe = 1'b0;
    end else if (op_dec == slic_pkg::SLIC_OP_RINGING) begin
      // hook output low on trip; ground-key output disabled here
      stat_next.hook_oe = 1'b1;
      stat_next.hook_o = !trip_reg;
    end else begin
      stat_next.hook_oe = 1'b1;
      stat_next.gka_oe = 1'b1;
      // both outputs are active-low fault flags over the hook level
      stat_next.hook_o = fault_low ? 1'b0 : line.off_hook;
      stat_next.gka_o = !(fault_low || line.ground_key);
    end
    if (sel_out_n) begin
      stat_next.hook_oe = 1'b0;
      stat_next.gka_oe = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      stat_reg <= '{hook_o: 1'b0, hook_oe: 1'b0, gka_o: 1'b0, gka_oe: 1'b0};
    end else begin
      stat_reg <= stat_next;
    end
  end

  assign hook_detect_out = stat_reg.hook_o;
  assign hook_detect_oe = stat_reg.hook_oe;
  assign ground_key_alarm_out = stat_reg.gka_o;
  assign ground_key_alarm_oe = stat_reg.gka_oe;
  assign ringing_relay_drive = relay_on_reg;

  // test relays follow their bits except under device reset
  assign test_relay_0 = dev_rst_n & latch_reg.relay[1];
  assign test_relay_1 = dev_rst_n & latch_reg.relay[0];

  assign op_mode = is_idle ? slic_pkg::SLIC_OP_POWER_DOWN : op_dec;
  assign auto_state = auto_reg;
  // hi-feed forces direct polarity whatever the word selects
  assign reverse_polarity = !is_idle &&
    ((op_dec == slic_pkg::SLIC_OP_OHT_REVERSE) ||
     (op_dec == slic_pkg::SLIC_OP_ACT_REVERSE &&
      auto_reg != slic_pkg::SLIC_ST_HI_FEED));
  assign power_down_active = is_idle;
endmodule

/* File: bench/slic_ring_source.sv */
// slic_ring_source: line card side source of the ring sync clock
// assumes core_clk only sets the time grid; phases count in clock cycles
`timescale 1ns/1ps
module slic_ring_source #(
  parameter int LOW_CYC = 250,
  parameter int HIGH_CYC = 250
) (
  // clock
  input wire logic core_clk,
  // ring timing
  output logic ring_sync_clock
);
  // never paused: the state change wait delay is timed by it
  initial begin
    ring_sync_clock = 1'h0;
    forever begin
      repeat (LOW_CYC) @(negedge core_clk);
      ring_sync_clock = 1'h1;
      repeat (HIGH_CYC) @(negedge core_clk);
      ring_sync_clock = 1'h0;
    end
  end
endmodule

/* File: bench/slic_ctrl_properties.sv */
// slic_ctrl_properties: timing checks on the activation control pins
// assumes binding into slic_ctrl; pin inputs lag up to four clocks
`timescale 1ns/1ps
module slic_ctrl_properties #(
  parameter int ONHOOK_PERIODS = 128
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // pins in
  input wire logic status_output_select_n,
  input wire logic device_reset_n,
  input wire logic ring_sync_clock,
  input wire logic line_ring_trip,
  input wire logic power_cross_sense_in,
  input wire logic long_current_fault,
  input wire logic thermal_overload,
  // pins out
  input wire logic hook_detect_out,
  input wire logic hook_detect_oe,
  input wire logic ground_key_alarm_out,
  input wire logic ground_key_alarm_oe,
  input wire logic ringing_relay_drive,
  input wire logic test_relay_0,
  input wire logic test_relay_1,
  input wire slic_pkg::slic_op_e op_mode,
  input wire slic_pkg::slic_auto_e auto_state,
  input wire logic reverse_polarity
);
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  chk_oe_idle: assert property (
    status_output_select_n [*5] |=> !hook_detect_oe && !ground_key_alarm_oe)
    else $error("status driven while deselected");
  chk_relay_reset: assert property (
    !device_reset_n [*4] |-> !test_relay_0 && !test_relay_1)
    else $error("test relay on during device reset");
  chk_pd_quiet: assert property (
    (op_mode == slic_pkg::SLIC_OP_POWER_DOWN && !thermal_overload) [*5]
    |-> !hook_detect_oe && !ground_key_alarm_oe)
    else $error("status driven in power down");
  chk_thermal_low: assert property (
    thermal_overload [*5]
    |-> !hook_detect_out && !ground_key_alarm_out && !ringing_relay_drive)
    else $error("thermal alarm not shown");
  chk_cross_low: assert property (
    (power_cross_sense_in && op_mode inside {slic_pkg::SLIC_OP_OHT_DIRECT,
    slic_pkg::SLIC_OP_ACT_DIRECT}) [*5]
    |-> !hook_detect_out && !ground_key_alarm_out)
    else $error("power cross not shown");
  chk_fault_low: assert property (
    (long_current_fault && op_mode == slic_pkg::SLIC_OP_OHT_DIRECT) [*5]
    |-> !hook_detect_out && !ground_key_alarm_out)
    else $error("line fault not shown");
  chk_trip_drop: assert property (
    (op_mode == slic_pkg::SLIC_OP_RINGING && line_ring_trip) [*5]
    |-> !ringing_relay_drive && !hook_detect_out)
    else $error("ring trip ignored");
  // two cycles of the same mode first: outputs trail the latch by one
  chk_trip_hold: assert property (
    op_mode == slic_pkg::SLIC_OP_RINGING &&
    $past(op_mode, 2) == slic_pkg::SLIC_OP_RINGING &&
    hook_detect_oe && !hook_detect_out
    ##1 op_mode == slic_pkg::SLIC_OP_RINGING && hook_detect_oe
    |-> !hook_detect_out)
    else $error("tripped hook output released");
  chk_ring_sync: assert property (
    $rose(ringing_relay_drive) |-> !$past(ring_sync_clock, 2) ||
    !$past(ring_sync_clock, 3) || !$past(ring_sync_clock, 4))
    else $error("ring relay on while ring clock high");
  chk_standby_first: assert property (
    auto_state == slic_pkg::SLIC_ST_HI_FEED
    |=> auto_state != slic_pkg::SLIC_ST_ACTIVE)
    else $error("active entered without stand-by");
  chk_hifeed_direct: assert property (
    auto_state == slic_pkg::SLIC_ST_HI_FEED &&
    op_mode == slic_pkg::SLIC_OP_ACT_REVERSE |-> !reverse_polarity)
    else $error("reverse polarity in high impedance feed");

  cov_activate: cover property (auto_state == slic_pkg::SLIC_ST_STANDBY
    ##1 auto_state == slic_pkg::SLIC_ST_ACTIVE);
  cov_fallback: cover property (auto_state == slic_pkg::SLIC_ST_ACTIVE
    ##1 auto_state == slic_pkg::SLIC_ST_HI_FEED);
  cov_trip: cover property ($fell(ringing_relay_drive) && line_ring_trip);
endmodule

bind slic_ctrl slic_ctrl_properties #(.ONHOOK_PERIODS(ONHOOK_PERIODS)) chk (
  .core_clk(core_clk), .resetn(resetn),
  .status_output_select_n(status_output_select_n),
  .device_reset_n(device_reset_n), .ring_sync_clock(ring_sync_clock),
  .line_ring_trip(line_ring_trip),
  .power_cross_sense_in(power_cross_sense_in),
  .long_current_fault(long_current_fault),
  .thermal_overload(thermal_overload), .hook_detect_out(hook_detect_out),
  .hook_detect_oe(hook_detect_oe),
  .ground_key_alarm_out(ground_key_alarm_out),
  .ground_key_alarm_oe(ground_key_alarm_oe),
  .ringing_relay_drive(ringing_relay_drive), .test_relay_0(test_relay_0),
  .test_relay_1(test_relay_1), .op_mode(op_mode), .auto_state(auto_state),
  .reverse_polarity(reverse_polarity)
);

/* File: bench/slic_ctrl_tb.sv */
// slic_ctrl_tb: directed bench for the activation control
// assumes a ring clock of 2 us from slic_ring_source; on-hook count of 4
`timescale 1ns/1ps
module slic_ctrl_tb;
  logic core_clk = 1'h0, resetn = 1'h0, device_reset_n = 1'h1;
  logic input_latch_select_n = 1'h1, status_output_select_n = 1'h1;
  logic mode_bit_0 = 1'h0, mode_bit_1 = 1'h0, mode_bit_2 = 1'h0;
  logic test_relay_bit_0 = 1'h0, test_relay_bit_1 = 1'h0;
  logic line_off_hook = 1'h0, line_ground_key = 1'h0, line_ring_trip = 1'h0;
  logic power_cross_sense_in = 1'h0, long_current_fault = 1'h0;
  logic thermal_overload = 1'h0;
  logic hook_detect_out, hook_detect_oe, ground_key_alarm_out;
  logic ground_key_alarm_oe, ringing_relay_drive, test_relay_0, test_relay_1;
  logic reverse_polarity, power_down_active, ring_sync_clock;
  slic_pkg::slic_op_e op_mode;
  slic_pkg::slic_auto_e auto_state;
  int err_count = 0;
  int comparisons = 0;

  always #2 core_clk = ~core_clk;

  slic_ring_source ring (.core_clk(core_clk),
    .ring_sync_clock(ring_sync_clock));

  // short on-hook count keeps the fallback run brief
  slic_ctrl #(.ONHOOK_PERIODS(4), .STANDBY_PERIODS(2)) dut (
    .core_clk(core_clk), .resetn(resetn),
    .input_latch_select_n(input_latch_select_n),
    .status_output_select_n(status_output_select_n),
    .mode_bit_0(mode_bit_0), .mode_bit_1(mode_bit_1),
    .mode_bit_2(mode_bit_2), .test_relay_bit_0(test_relay_bit_0),
    .test_relay_bit_1(test_relay_bit_1), .device_reset_n(device_reset_n),
    .ring_sync_clock(ring_sync_clock), .line_off_hook(line_off_hook),
    .line_ground_key(line_ground_key), .line_ring_trip(line_ring_trip),
    .power_cross_sense_in(power_cross_sense_in),
    .long_current_fault(long_current_fault),
    .thermal_overload(thermal_overload), .hook_detect_out(hook_detect_out),
    .hook_detect_oe(hook_detect_oe),
    .ground_key_alarm_out(ground_key_alarm_out),
    .ground_key_alarm_oe(ground_key_alarm_oe),
    .ringing_relay_drive(ringing_relay_drive), .test_relay_0(test_relay_0),
    .test_relay_1(test_relay_1), .op_mode(op_mode), .auto_state(auto_state),
    .reverse_polarity(reverse_polarity),
    .power_down_active(power_down_active)
  );

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [2:0] got, input logic [2:0] exp,
    input string msg);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic tmo(input logic ok);
    if (ok !== 1'h1) begin
      err_count++;
      $display("wrong value at %0t ns: wait ran out", $time);
      conclude();
    end
  endtask

  task automatic nap(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // bits settle three cycles before the select so no mixed word is caught
  task automatic wr(input logic [2:0] w, input logic [1:0] r);
    @(negedge core_clk);
    {mode_bit_0, mode_bit_1, mode_bit_2} = w;
    {test_relay_bit_1, test_relay_bit_0} = r;
    nap(3);
    input_latch_select_n = 1'h0;
    nap(5);
    input_latch_select_n = 1'h1;
    nap(5);
  endtask

  task automatic wait_st(input slic_pkg::slic_auto_e s);
    for (int i = 0; i < 1500 && auto_state !== s; i++) begin
      nap(1);
    end
    tmo(auto_state === s);
  endtask

  task automatic ring_on();
    for (int i = 0; i < 600 && ringing_relay_drive !== 1'h1; i++) begin
      nap(1);
    end
    tmo(ringing_relay_drive === 1'h1);
  endtask

  function automatic slic_pkg::slic_op_e exp_op(input logic [2:0] w);
    case (w)
      3'h0: return slic_pkg::SLIC_OP_POWER_DOWN;
      3'h1: return slic_pkg::SLIC_OP_RINGING;
      3'h2: return slic_pkg::SLIC_OP_OHT_REVERSE;
      3'h3: return slic_pkg::SLIC_OP_OHT_DIRECT;
      3'h6: return slic_pkg::SLIC_OP_ACT_REVERSE;
      default: return slic_pkg::SLIC_OP_ACT_DIRECT;
    endcase
  endfunction

  initial begin
    nap(20);
    resetn = 1'h1;
    nap(5);
    chk({hook_detect_oe, ground_key_alarm_oe}, 3'h0, "oe");
    chk(auto_state, slic_pkg::SLIC_ST_HI_FEED, "state");
    for (int w = 0; w < 8; w++) begin
      wr(w[2:0], w[1:0]);
      chk(op_mode, exp_op(w[2:0]), "decode");
      chk({test_relay_1, test_relay_0}, w[1:0], "relay");
      chk(reverse_polarity, w == 2, "polarity");
      chk(power_down_active, w == 0, "power down");
    end
    {mode_bit_0, mode_bit_1, mode_bit_2} = 3'h0;
    nap(8);
    chk(op_mode, slic_pkg::SLIC_OP_ACT_DIRECT, "ignored");
    $display("test decode done");
    wr(3'h0, 2'h3);
    status_output_select_n = 1'h0;
    nap(8);
    chk({hook_detect_oe, ground_key_alarm_oe}, 3'h0, "pd oe");
    chk({test_relay_1, test_relay_0}, 3'h3, "pd relay");
    wr(3'h1, 2'h2);
    ring_on();
    chk(hook_detect_out, 3'h1, "ring hook");
    thermal_overload = 1'h1;
    nap(8);
    chk({hook_detect_out, ground_key_alarm_out}, 3'h0, "hot");
    chk(ringing_relay_drive, 3'h0, "hot ring");
    chk({test_relay_1, test_relay_0, hook_detect_oe}, 3'h5, "hot");
    wr(3'h3, 2'h0);
    thermal_overload = 1'h0;
    $display("test idle done");
    wr(3'h1, 2'h0);
    ring_on();
    line_ring_trip = 1'h1;
    nap(8);
    chk({ringing_relay_drive, hook_detect_out}, 3'h0, "trip");
    line_ring_trip = 1'h0;
    nap(8);
    chk(hook_detect_out, 3'h0, "trip hold");
    line_off_hook = 1'h1;
    wr(3'h3, 2'h0);
    chk(hook_detect_out, 3'h1, "new mode");
    chk(ground_key_alarm_out, 3'h1, "no key");
    line_ground_key = 1'h1;
    nap(8);
    chk(ground_key_alarm_out, 3'h0, "key");
    line_ground_key = 1'h0;
    power_cross_sense_in = 1'h1;
    nap(8);
    chk({hook_detect_out, ground_key_alarm_out}, 3'h0, "cross");
    chk(op_mode, slic_pkg::SLIC_OP_OHT_DIRECT, "cross mode");
    power_cross_sense_in = 1'h0;
    long_current_fault = 1'h1;
    nap(8);
    chk({hook_detect_out, ground_key_alarm_out}, 3'h0, "fault");
    long_current_fault = 1'h0;
    nap(8);
    chk({hook_detect_out, ground_key_alarm_out}, 3'h3, "clear");
    line_off_hook = 1'h0;
    nap(8);
    chk(op_mode, slic_pkg::SLIC_OP_OHT_DIRECT, "oht");
    $display("test ringing and faults done");
    wr(3'h4, 2'h0);
    chk(auto_state, slic_pkg::SLIC_ST_HI_FEED, "hi feed");
    line_off_hook = 1'h1;
    nap(8);
    chk(auto_state, slic_pkg::SLIC_ST_STANDBY, "standby");
    wait_st(slic_pkg::SLIC_ST_ACTIVE);
    chk(hook_detect_out, 3'h1, "live off");
    line_off_hook = 1'h0;
    nap(300);
    chk(hook_detect_out, 3'h0, "live on");
    line_off_hook = 1'h1;
    nap(8);
    chk(auto_state, slic_pkg::SLIC_ST_ACTIVE, "dial pulse");
    line_off_hook = 1'h0;
    nap(1500);
    chk(auto_state, slic_pkg::SLIC_ST_ACTIVE, "early");
    wait_st(slic_pkg::SLIC_ST_HI_FEED);
    line_off_hook = 1'h1;
    nap(8);
    chk(auto_state, slic_pkg::SLIC_ST_STANDBY, "spurious");
    line_off_hook = 1'h0;
    wait_st(slic_pkg::SLIC_ST_HI_FEED);
    wr(3'h6, 2'h3);
    line_off_hook = 1'h1;
    wait_st(slic_pkg::SLIC_ST_ACTIVE);
    chk(reverse_polarity, 3'h1, "reverse active");
    line_off_hook = 1'h0;
    nap(3000);
    chk(auto_state, slic_pkg::SLIC_ST_ACTIVE, "reverse");
    $display("test automatic done");
    device_reset_n = 1'h0;
    nap(8);
    chk({test_relay_1, test_relay_0, hook_detect_oe}, 3'h0, "rst");
    chk(power_down_active, 3'h1, "rst pd");
    $display("test device reset done");
    conclude();
  end
endmodule
